// ### hw/sfsr_dev.sv
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`include "sfsr_regs.svh"
module sfsr_dev (
  input wire logic REF_CLK,
  input wire logic RESETN,
  sfsr_link_if.dev LINK,
  input wire logic MEM_WE,
  input wire logic [7:0] MEM_ADDR,
  input wire logic [7:0] MEM_WDATA,
  output logic [15:0] STATUS
);
  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  // order: 0 chip select, 1 serial clock, 2 serial_in
  logic [2:0] s1, s2, s3, filt, next_filt;
  logic cs_rise, cs_fall, sck_rise, sck_fall, din;

  // a change counts once the second and third stages agree
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      next_filt[i] = (s2[i] == s3[i]) ? s3[i] : filt[i];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      s1 <= 3'h1;
      s2 <= 3'h1;
      s3 <= 3'h1;
      filt <= 3'h1;
    end else begin
      s1 <= {LINK.io0, LINK.sclk, LINK.cs_n};
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
    end
  end

  // edges and data all come from the same filtered stage, so they stay aligned
  assign cs_rise = next_filt[0] & ~filt[0];
  assign cs_fall = ~next_filt[0] & filt[0];
  assign sck_rise = next_filt[1] & ~filt[1] & ~filt[0];
  assign sck_fall = ~next_filt[1] & filt[1] & ~filt[0];
  assign din = next_filt[2];

  // ----------------------------------------
  // memory array, loaded from the user side
  // ----------------------------------------
  logic [7:0] mem [`SFSR_MEM_DEPTH];

  // loader port only; no program commands exist in this block
  always_ff @(posedge REF_CLK) begin
    if (MEM_WE) begin
      mem[MEM_ADDR] <= MEM_WDATA;
    end
  end

  // ----------------------------------------
  // command engine
  // ----------------------------------------
  sfsr_pkg::sfsr_dev_state_type state, next_state;
  logic [4:0] cnt, next_cnt;
  logic [23:0] shreg, next_shreg;
  logic [23:0] addr, next_addr;
  logic [7:0] opc, next_opc;
  logic [7:0] osh, next_osh;
  logic [2:0] ocnt, next_ocnt;
  logic do1, next_do1, do0, next_do0, oe1, next_oe1, oe0, next_oe0;
  logic [15:0] sr, next_sr, pend, next_pend;
  logic write_latch, next_wel, vol_en, next_vol_en;
  logic [15:0] wcnt, next_wcnt, rcnt, next_rcnt;
  logic busy;
  logic [7:0] sr_lo, sr_hi, obyte, b1, b2, op_in;
  logic [15:0] wr_val;
  logic wr_len_ok;

  assign busy = (wcnt != 16'h0000);
  assign sr_lo = {sr[7:2], write_latch, busy};
  assign sr_hi = sr[15:8];
  assign op_in = {shreg[6:0], din};

  // candidate status value from the collected write bits
  always_comb begin
    wr_len_ok = (cnt == 5'h08) || (cnt == 5'h10);
    b1 = (cnt == 5'h08) ? shreg[7:0] : shreg[15:8];
    b2 = shreg[7:0];
    if (cnt == 5'h08) begin
      b2 = sr_hi;
      b2[`SFSR_SR_CMP - 8] = 1'b0;
      b2[`SFSR_SR_QUAD - 8] = 1'b0;
      b2[`SFSR_SR_PROT1 - 8] = 1'b0;
    end
    // read-only positions keep their value
    wr_val = {sr[15], b2[6:0], b1[7:2], 2'b00};
    // lock bits are one-time programmable
    wr_val[`SFSR_SR_LOCK_HI:`SFSR_SR_LOCK_LO] =
      b2[5:2] | sr[`SFSR_SR_LOCK_HI:`SFSR_SR_LOCK_LO];
  end

  // byte to shift out next: status or memory
  always_comb begin
    if (opc == `SFSR_OP_STAT1_READ) begin
      obyte = sr_lo;
    end else if (opc == `SFSR_OP_STAT2_READ) begin
      obyte = sr_hi;
    end else begin
      obyte = mem[addr[7:0]];
    end
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shreg = shreg;
    next_addr = addr;
    next_opc = opc;
    next_osh = osh;
    next_ocnt = ocnt;
    next_do1 = do1;
    next_do0 = do0;
    next_oe1 = oe1;
    next_oe0 = oe0;
    next_sr = sr;
    next_pend = pend;
    next_wel = write_latch;
    next_vol_en = vol_en;
    next_wcnt = wcnt;
    next_rcnt = rcnt;
    // self-timed cycles; commit on the last count
    if (wcnt != 16'h0000) begin
      next_wcnt = wcnt - 16'h0001;
      if (wcnt == 16'h0001) begin
        next_sr = pend;
        next_wel = 1'b0;
      end
    end
    if (rcnt != 16'h0000) begin
      next_rcnt = rcnt - 16'h0001;
      if (rcnt == 16'h0001) begin
        next_sr = pend;
      end
    end
    if (cs_rise) begin
      next_state = sfsr_pkg::D_IDLE;
      next_oe1 = 1'b0;
      next_oe0 = 1'b0;
      // status write executes only on a clean 8 or 16 bit frame
      if (state == sfsr_pkg::D_SRW && wr_len_ok && !busy) begin
        if (vol_en) begin
          next_pend = wr_val;
          next_rcnt = 16'(`SFSR_REFRESH_CYCLES);
          next_vol_en = 1'b0;
        end else if (write_latch) begin
          next_pend = wr_val;
          next_wcnt = 16'(`SFSR_WRITE_CYCLES);
        end
      end
    end else if (cs_fall) begin
      next_state = sfsr_pkg::D_OPC;
      next_cnt = 5'h00;
    end else if (sck_rise) begin
      next_shreg = {shreg[22:0], din};
      case (state)
        sfsr_pkg::D_OPC: begin
          next_cnt = cnt + 5'h01;
          if (cnt == 5'h07) begin
            next_opc = op_in;
            next_cnt = 5'h00;
            next_ocnt = 3'h0;
            next_state = sfsr_pkg::D_SKIP;
            case (op_in)
              `SFSR_OP_WR_ENABLE: begin
                if (!busy) next_wel = 1'b1;
              end
              `SFSR_OP_VOL_ENABLE: begin
                if (!busy) next_vol_en = 1'b1;
              end
              `SFSR_OP_WR_DISABLE: begin
                if (!busy) begin
                  next_wel = 1'b0;
                  next_vol_en = 1'b0;
                end
              end
              `SFSR_OP_STAT1_READ, `SFSR_OP_STAT2_READ: begin
                next_state = sfsr_pkg::D_OUT;
              end
              `SFSR_OP_STAT_WRITE: begin
                if (!busy) next_state = sfsr_pkg::D_SRW;
              end
              `SFSR_OP_READ, `SFSR_OP_FAST_READ, `SFSR_OP_DUAL_READ: begin
                if (!busy) next_state = sfsr_pkg::D_ADDR;
              end
              default: begin
                next_state = sfsr_pkg::D_SKIP;
              end
            endcase
          end
        end
        sfsr_pkg::D_ADDR: begin
          next_cnt = cnt + 5'h01;
          if (cnt == 5'h17) begin
            next_addr = {shreg[22:0], din};
            next_cnt = 5'h00;
            next_state = (opc == `SFSR_OP_READ) ? sfsr_pkg::D_OUT : sfsr_pkg::D_DUMMY;
          end
        end
        sfsr_pkg::D_DUMMY: begin
          next_cnt = cnt + 5'h01;
          if (cnt == 5'(`SFSR_DUMMY_CLOCKS - 1)) begin
            next_state = sfsr_pkg::D_OUT;
          end
        end
        sfsr_pkg::D_SRW: begin
          // saturates so an overlong frame stays invalid
          if (cnt != 5'h1f) next_cnt = cnt + 5'h01;
        end
        default: begin
          next_state = state;
        end
      endcase
    end else if (sck_fall && state == sfsr_pkg::D_OUT) begin
      next_oe1 = 1'b1;
      if (ocnt == 3'h0) begin
        // status bytes repeat; memory reads walk upward
        if (opc != `SFSR_OP_STAT1_READ && opc != `SFSR_OP_STAT2_READ) begin
          next_addr = addr + 24'h000001;
        end
        if (opc == `SFSR_OP_DUAL_READ) begin
          next_oe0 = 1'b1;
          next_do1 = obyte[7];
          next_do0 = obyte[6];
          next_osh = {obyte[5:0], 2'b00};
          next_ocnt = 3'h3;
        end else begin
          next_do1 = obyte[7];
          next_osh = {obyte[6:0], 1'b0};
          next_ocnt = 3'h7;
        end
      end else begin
        next_do1 = osh[7];
        next_ocnt = ocnt - 3'h1;
        if (opc == `SFSR_OP_DUAL_READ) begin
          next_do0 = osh[6];
          next_osh = {osh[5:0], 2'b00};
        end else begin
          next_osh = {osh[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      state <= sfsr_pkg::D_IDLE;
      cnt <= 5'h00;
      shreg <= 24'h000000;
      addr <= 24'h000000;
      opc <= 8'h00;
      osh <= 8'h00;
      ocnt <= 3'h0;
      do1 <= 1'b0;
      do0 <= 1'b0;
      oe1 <= 1'b0;
      oe0 <= 1'b0;
      sr <= `SFSR_SR_RESET;
      pend <= `SFSR_SR_RESET;
      write_latch <= 1'b0;
      vol_en <= 1'b0;
      wcnt <= 16'h0000;
      rcnt <= 16'h0000;
      STATUS <= 16'h0000;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shreg <= next_shreg;
      addr <= next_addr;
      opc <= next_opc;
      osh <= next_osh;
      ocnt <= next_ocnt;
      do1 <= next_do1;
      do0 <= next_do0;
      oe1 <= next_oe1;
      oe0 <= next_oe0;
      sr <= next_sr;
      pend <= next_pend;
      write_latch <= next_wel;
      vol_en <= next_vol_en;
      wcnt <= next_wcnt;
      rcnt <= next_rcnt;
      STATUS <= {sr_hi, sr_lo};
    end
  end

  assign LINK.dev_io1_o = do1;
  assign LINK.dev_io1_oe = oe1;
  assign LINK.dev_io0_o = do0;
  assign LINK.dev_io0_oe = oe0;
endmodule

// ### hw/sfsr_regs.svh
`ifndef SFSR_REGS_SVH
`define SFSR_REGS_SVH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define SFSR_OP_WR_ENABLE 8'h06
`define SFSR_OP_VOL_ENABLE 8'h50
`define SFSR_OP_WR_DISABLE 8'h04
`define SFSR_OP_STAT1_READ 8'h05
`define SFSR_OP_STAT2_READ 8'h35
`define SFSR_OP_STAT_WRITE 8'h01
`define SFSR_OP_READ 8'h03
`define SFSR_OP_FAST_READ 8'h0b
`define SFSR_OP_DUAL_READ 8'h3b

// ----------------------------------------
// status layout
// ----------------------------------------
`define SFSR_SR_BUSY 0
`define SFSR_SR_LATCH 1
`define SFSR_SR_PROT1 8
`define SFSR_SR_QUAD 9
`define SFSR_SR_LOCK_LO 10
`define SFSR_SR_LOCK_HI 13
`define SFSR_SR_CMP 14
`define SFSR_SR_RESET 16'h0000

// ----------------------------------------
// timing
// ----------------------------------------
`define SFSR_CLK_PERIOD_NS 10
`define SFSR_T_WRITE_NS 10000
`define SFSR_WRITE_CYCLES (`SFSR_T_WRITE_NS / `SFSR_CLK_PERIOD_NS)
`define SFSR_T_REFRESH_NS 50
`define SFSR_REFRESH_CYCLES (`SFSR_T_REFRESH_NS / `SFSR_CLK_PERIOD_NS)
`define SFSR_HALF_CYCLES 8
`define SFSR_DUMMY_CLOCKS 8

// ----------------------------------------
// host register map
// ----------------------------------------
`define SFSR_REG_CMD 4'h0
`define SFSR_REG_ADDR 4'h4
`define SFSR_REG_TXDATA 4'h8
`define SFSR_REG_RXDATA 4'hc
`define SFSR_CMD_DUMMY 11
`define SFSR_CMD_ADDR 10
`define SFSR_CMD_DUAL 12
`define SFSR_MEM_DEPTH 256
`endif

// ### hw/sfsr_pkg.sv
package sfsr_pkg;
  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_OPC = 3'h1,
    D_ADDR = 3'h2,
    D_DUMMY = 3'h3,
    D_OUT = 3'h4,
    D_SRW = 3'h5,
    D_SKIP = 3'h6
  } sfsr_dev_state_type;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_LOW = 3'h1,
    H_HIGH = 3'h2,
    H_END = 3'h3,
    H_GAP = 3'h4
  } sfsr_host_state_type;
endpackage

// ### hw/sfsr_link_if.sv
`timescale 1ns/10ps
interface sfsr_link_if;
  logic cs_n;
  logic sclk;
  logic host_io0_o;
  logic host_io0_oe;
  logic dev_io0_o;
  logic dev_io0_oe;
  logic dev_io1_o;
  logic dev_io1_oe;
  logic io0;
  logic io1;

  // wire levels from the enables; an undriven lane floats high
  assign io0 = host_io0_oe ? host_io0_o : (dev_io0_oe ? dev_io0_o : 1'b1);
  assign io1 = dev_io1_oe ? dev_io1_o : 1'b1;

  modport host (output cs_n, output sclk, output host_io0_o, output host_io0_oe,
                input io0, input io1);
  modport dev (input cs_n, input sclk, input io0, output dev_io0_o,
               output dev_io0_oe, output dev_io1_o, output dev_io1_oe);
endinterface

// ### hw/sfsr_host.sv
`timescale 1ns/10ps
`include "sfsr_regs.svh"
module sfsr_host (
  input wire logic REF_CLK,
  input wire logic RESETN,
  sfsr_link_if.host LINK,
  input wire logic [3:0] BUS_ADDR,
  input wire logic [31:0] BUS_WDATA,
  input wire logic BUS_WR,
  input wire logic BUS_RD,
  output logic [31:0] BUS_RDATA
);
  // ----------------------------------------
  // returning lanes, three stages each
  // ----------------------------------------
  logic [1:0] s1, s2, s3, filt, next_filt;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_filt[i] = (s2[i] == s3[i]) ? s3[i] : filt[i];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      s1 <= 2'h3;
      s2 <= 2'h3;
      s3 <= 2'h3;
      filt <= 2'h3;
    end else begin
      s1 <= {LINK.io1, LINK.io0};
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
    end
  end

  // ----------------------------------------
  // frame engine and register slave
  // ----------------------------------------
  sfsr_pkg::sfsr_host_state_type state, next_state;
  logic [2:0] half, next_half;
  logic [55:0] tx_sh, next_tx_sh, frame;
  logic [5:0] tx_left, next_tx_left;
  logic [10:0] rx_left, next_rx_left;
  logic dual, next_dual, cs_n, next_cs_n, sclk, next_sclk;
  logic io_o, next_io_o, io_oe, next_io_oe;
  logic [31:0] rx_sh, next_rx_sh, next_rdata;
  logic [23:0] addr, next_addr;
  logic [15:0] txdata, next_txdata;
  logic last_clk;
  int n;

  // left-aligned outgoing bits: opcode, address, dummy, data
  always_comb begin
    n = 8;
    frame = {BUS_WDATA[7:0], 48'h0};
    if (BUS_WDATA[`SFSR_CMD_ADDR]) begin
      frame[47 -: 24] = addr;
      n = n + 24;
    end
    if (BUS_WDATA[`SFSR_CMD_DUMMY]) begin
      n = n + `SFSR_DUMMY_CLOCKS;
    end
    if (BUS_WDATA[9:8] == 2'h1) begin
      frame[55 - n -: 8] = txdata[7:0];
      n = n + 8;
    end else if (BUS_WDATA[9:8] != 2'h0) begin
      frame[55 - n -: 16] = txdata;
      n = n + 16;
    end
  end

  assign last_clk = (tx_left == 6'h00 && rx_left <= 11'h001) ||
                    (tx_left == 6'h01 && rx_left == 11'h000);

  always_comb begin
    next_state = state;
    next_half = half + 3'h1;
    next_tx_sh = tx_sh;
    next_tx_left = tx_left;
    next_rx_left = rx_left;
    next_dual = dual;
    next_cs_n = cs_n;
    next_sclk = sclk;
    next_io_o = io_o;
    next_io_oe = io_oe;
    next_rx_sh = rx_sh;
    next_addr = addr;
    next_txdata = txdata;
    next_rdata = 32'h0;
    if (BUS_RD) begin
      case (BUS_ADDR)
        `SFSR_REG_ADDR: next_rdata = {8'h00, addr};
        `SFSR_REG_TXDATA: next_rdata = {16'h0000, txdata};
        `SFSR_REG_RXDATA: next_rdata = rx_sh;
        `SFSR_REG_CMD: next_rdata = {31'h0, state != sfsr_pkg::H_IDLE};
        default: next_rdata = 32'h0;
      endcase
    end
    if (BUS_WR && BUS_ADDR == `SFSR_REG_ADDR) next_addr = BUS_WDATA[23:0];
    if (BUS_WR && BUS_ADDR == `SFSR_REG_TXDATA) next_txdata = BUS_WDATA[15:0];
    case (state)
      sfsr_pkg::H_IDLE: begin
        next_half = 3'h0;
        // a frame starts by selecting and presenting the opcode MSB
        if (BUS_WR && BUS_ADDR == `SFSR_REG_CMD) begin
          next_state = sfsr_pkg::H_LOW;
          next_tx_sh = frame;
          next_tx_left = 6'(n);
          next_dual = BUS_WDATA[`SFSR_CMD_DUAL];
          next_rx_left = BUS_WDATA[`SFSR_CMD_DUAL] ? {1'b0, BUS_WDATA[23:16], 2'b00} :
                                                     {BUS_WDATA[23:16], 3'b000};
          next_cs_n = 1'b0;
          next_io_o = frame[55];
          next_io_oe = 1'b1;
          next_rx_sh = 32'h0;
        end
      end
      sfsr_pkg::H_LOW: begin
        if (half == 3'(`SFSR_HALF_CYCLES - 1)) begin
          next_sclk = 1'b1;
          next_state = sfsr_pkg::H_HIGH;
        end
      end
      sfsr_pkg::H_HIGH: begin
        // lane 0 let go well before the device drives data
        if (half == 3'h3 && tx_left == 6'h01) next_io_oe = 1'b0;
        if (half == 3'(`SFSR_HALF_CYCLES - 1)) begin
          next_sclk = 1'b0;
          if (tx_left != 6'h00) begin
            next_tx_left = tx_left - 6'h01;
            next_tx_sh = {tx_sh[54:0], 1'b0};
            next_io_o = tx_sh[54];
          end else begin
            next_rx_left = rx_left - 11'h001;
            // sampled late in the high half, where device data is settled
            next_rx_sh = dual ? {rx_sh[29:0], filt[1], filt[0]} : {rx_sh[30:0], filt[1]};
          end
          next_state = last_clk ? sfsr_pkg::H_END : sfsr_pkg::H_LOW;
        end
      end
      sfsr_pkg::H_END: begin
        if (half == 3'(`SFSR_HALF_CYCLES - 1)) begin
          next_cs_n = 1'b1;
          next_io_oe = 1'b0;
          next_state = sfsr_pkg::H_GAP;
        end
      end
      sfsr_pkg::H_GAP: begin
        if (half == 3'(`SFSR_HALF_CYCLES - 1)) next_state = sfsr_pkg::H_IDLE;
      end
      default: begin
        next_state = sfsr_pkg::H_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      state <= sfsr_pkg::H_IDLE;
      half <= 3'h0;
      tx_sh <= 56'h0;
      tx_left <= 6'h00;
      rx_left <= 11'h000;
      dual <= 1'b0;
      cs_n <= 1'b1;
      sclk <= 1'b0;
      io_o <= 1'b0;
      io_oe <= 1'b0;
      rx_sh <= 32'h0;
      addr <= 24'h000000;
      txdata <= 16'h0000;
      BUS_RDATA <= 32'h0;
    end else begin
      state <= next_state;
      half <= next_half;
      tx_sh <= next_tx_sh;
      tx_left <= next_tx_left;
      rx_left <= next_rx_left;
      dual <= next_dual;
      cs_n <= next_cs_n;
      sclk <= next_sclk;
      io_o <= next_io_o;
      io_oe <= next_io_oe;
      rx_sh <= next_rx_sh;
      addr <= next_addr;
      txdata <= next_txdata;
      BUS_RDATA <= next_rdata;
    end
  end

  assign LINK.cs_n = cs_n;
  assign LINK.sclk = sclk;
  assign LINK.host_io0_o = io_o;
  assign LINK.host_io0_oe = io_oe;
endmodule

// ### verification/sfsr_checker.sv
`timescale 1ns/10ps
module sfsr_checker (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic host_io0_oe,
  input wire logic dev_io0_o,
  input wire logic dev_io0_oe,
  input wire logic dev_io1_o,
  input wire logic dev_io1_oe
);
  // ----------------------------------------
  // link checks, all in the one clock domain
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);

  // mode 0: clock rests low outside frames
  a_idle_clock_low: assert property (cs_n |-> !sclk)
    else $error("serial clock high while deselected");
  // first rising edge comes a full low half after select
  a_first_rise_lead: assert property ($fell(cs_n) |-> !sclk [*8] ##1 sclk)
    else $error("first clock rise not eight cycles after select");
  // opcode bit 7 is already on lane 0 when select falls
  a_opcode_driven: assert property ($fell(cs_n) |-> host_io0_oe)
    else $error("host lane 0 not driven at frame start");
  a_high_half_len: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("clock high half not eight cycles");
  a_low_half_len: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("clock low half shorter than eight cycles");
  // two drivers on lane 0 would corrupt dual data
  a_lane_no_clash: assert property (host_io0_oe |-> !dev_io0_oe)
    else $error("host and device both drive lane 0");
  a_host_quiet: assert property (cs_n |-> !host_io0_oe)
    else $error("host drives lane 0 while deselected");
  // the synchronisers add a few cycles before the device lets go
  a_dev_release: assert property (cs_n [*8] |-> !dev_io1_oe && !dev_io0_oe)
    else $error("device still drives after deselect");
  // output bits change only after falling edges
  a_out_stable_high: assert property (sclk && $past(sclk) && dev_io1_oe && $past(dev_io1_oe)
    |-> $stable(dev_io1_o) && $stable(dev_io0_o))
    else $error("device data changed while clock high");
  a_dual_lane_pair: assert property (dev_io0_oe |-> dev_io1_oe)
    else $error("lane 0 driven without lane 1");

  c_dual_out: cover property ($rose(dev_io0_oe));
  c_single_out: cover property ($rose(dev_io1_oe) && !dev_io0_oe);
  c_frame_end: cover property ($rose(cs_n));
endmodule

// ### verification/tb_serial_flash_status_and_read_cmds.sv
`timescale 1ns/10ps
`include "sfsr_regs.svh"
module tb_serial_flash_status_and_read_cmds;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] bus_addr = 4'h0;
  logic [31:0] bus_wdata = 32'h0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [31:0] bus_rdata;
  logic mem_we = 1'b0;
  logic [7:0] mem_addr = 8'h00;
  logic [7:0] mem_wdata = 8'h00;
  logic [15:0] status;
  logic [31:0] rx;
  int failures = 0;
  int tests_run = 0;

  // free-running system clock
  always #5 ref_clk = ~ref_clk;

  sfsr_link_if u_sfsr_link_if ();
  sfsr_dev u_sfsr_dev (.REF_CLK(ref_clk), .RESETN(resetn), .LINK(u_sfsr_link_if),
    .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .STATUS(status));
  sfsr_host u_sfsr_host (.REF_CLK(ref_clk), .RESETN(resetn), .LINK(u_sfsr_link_if),
    .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata), .BUS_WR(bus_wr), .BUS_RD(bus_rd),
    .BUS_RDATA(bus_rdata));
  sfsr_checker u_sfsr_checker (.REF_CLK(ref_clk), .RESETN(resetn),
    .cs_n(u_sfsr_link_if.cs_n), .sclk(u_sfsr_link_if.sclk),
    .host_io0_oe(u_sfsr_link_if.host_io0_oe), .dev_io0_o(u_sfsr_link_if.dev_io0_o),
    .dev_io0_oe(u_sfsr_link_if.dev_io0_oe), .dev_io1_o(u_sfsr_link_if.dev_io1_o),
    .dev_io1_oe(u_sfsr_link_if.dev_io1_oe));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  function automatic logic [7:0] pat(input int i);
    return 8'(i * 7 + 3);
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask

  // a hung frame must not stall the poll forever
  task automatic wait_idle;
    logic [31:0] d;
    int n;
    n = 0;
    d = 32'h1;
    while (d[0] !== 1'b0 && n < 2000) begin
      bus_read(`SFSR_REG_CMD, d);
      n++;
    end
    if (n >= 2000) check("idle wait", 32'h1, 32'h0);
  endtask

  // mode: bit2 dual, bit1 dummy clocks, bit0 address
  task automatic xfer(input logic [7:0] op, input logic [1:0] ntx, input logic [15:0] tx,
                      input logic [23:0] a, input logic [2:0] mode, input logic [7:0] nrx);
    bus_write(`SFSR_REG_ADDR, {8'h00, a});
    bus_write(`SFSR_REG_TXDATA, {16'h0000, tx});
    bus_write(`SFSR_REG_CMD, {8'h00, nrx, 3'h0, mode, ntx, op});
    wait_idle;
    bus_read(`SFSR_REG_RXDATA, rx);
  endtask

  task automatic cmd1(input logic [7:0] op);
    xfer(op, 2'd0, 16'h0000, 24'h000000, 3'h0, 8'h00);
  endtask

  task automatic expect_sts(input logic [7:0] op, input logic [7:0] exp);
    xfer(op, 2'd0, 16'h0000, 24'h000000, 3'h0, 8'h01);
    check("status byte", {24'h0, rx[7:0]}, {24'h0, exp});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_latch;
    expect_sts(`SFSR_OP_STAT1_READ, 8'h00);
    cmd1(`SFSR_OP_WR_ENABLE);
    xfer(`SFSR_OP_STAT1_READ, 2'd0, 16'h0000, 24'h000000, 3'h0, 8'h02);
    check("repeated status", {16'h0, rx[15:0]}, 32'h0202);
    cmd1(`SFSR_OP_WR_DISABLE);
    expect_sts(`SFSR_OP_STAT1_READ, 8'h00);
    // an unknown opcode leaves both lanes released, so lane 1 floats high
    xfer(8'h00, 2'd0, 16'h0000, 24'h000000, 3'h0, 8'h01);
    check("unknown opcode", {24'h0, rx[7:0]}, 32'hff);
    $display("test latch done");
  endtask

  task automatic t_nv;
    cmd1(`SFSR_OP_WR_ENABLE);
    xfer(`SFSR_OP_STAT_WRITE, 2'd2, 16'hffff, 24'h000000, 3'h0, 8'h00);
    expect_sts(`SFSR_OP_STAT1_READ, 8'h03);
    // device ignores the read, so lane 1 floats high
    xfer(`SFSR_OP_READ, 2'd0, 16'h0000, 24'h000010, 3'h1, 8'h01);
    check("read while busy", {24'h0, rx[7:0]}, 32'hff);
    repeat (1200) @(posedge ref_clk);
    // look off the edge so the port has settled
    #1;
    check("status port", {16'h0, status}, 32'h7ffc);
    expect_sts(`SFSR_OP_STAT1_READ, 8'hfc);
    expect_sts(`SFSR_OP_STAT2_READ, 8'h7f);
    $display("test nonvolatile done");
  endtask

  task automatic t_short;
    cmd1(`SFSR_OP_WR_ENABLE);
    xfer(`SFSR_OP_STAT_WRITE, 2'd1, 16'h0000, 24'h000000, 3'h0, 8'h00);
    repeat (1200) @(posedge ref_clk);
    expect_sts(`SFSR_OP_STAT1_READ, 8'h00);
    expect_sts(`SFSR_OP_STAT2_READ, 8'h3c);
    // 24 data bits instead of 8 or 16: discarded, no write cycle
    cmd1(`SFSR_OP_WR_ENABLE);
    xfer(`SFSR_OP_STAT_WRITE, 2'd0, 16'h0000, 24'hffffff, 3'h1, 8'h00);
    expect_sts(`SFSR_OP_STAT1_READ, 8'h02);
    cmd1(`SFSR_OP_WR_DISABLE);
    $display("test short write done");
  endtask

  task automatic t_vol;
    cmd1(`SFSR_OP_VOL_ENABLE);
    expect_sts(`SFSR_OP_STAT1_READ, 8'h00);
    xfer(`SFSR_OP_STAT_WRITE, 2'd2, 16'h2800, 24'h000000, 3'h0, 8'h00);
    check("busy in refresh", {31'h0, status[0]}, 32'h0);
    expect_sts(`SFSR_OP_STAT1_READ, 8'h28);
    expect_sts(`SFSR_OP_STAT2_READ, 8'h3c);
    cmd1(`SFSR_OP_VOL_ENABLE);
    cmd1(`SFSR_OP_WR_DISABLE);
    xfer(`SFSR_OP_STAT_WRITE, 2'd2, 16'h0000, 24'h000000, 3'h0, 8'h00);
    repeat (20) @(posedge ref_clk);
    expect_sts(`SFSR_OP_STAT1_READ, 8'h28);
    $display("test volatile done");
  endtask

  task automatic t_reads;
    logic [7:0] ops [3];
    logic [2:0] modes [3];
    int base;
    ops = '{`SFSR_OP_READ, `SFSR_OP_FAST_READ, `SFSR_OP_DUAL_READ};
    modes = '{3'h1, 3'h3, 3'h7};
    for (int k = 0; k < 3; k++) begin
      base = 16 + 32 * k;
      xfer(ops[k], 2'd0, 16'h0000, 24'(base), modes[k], 8'h03);
      check("read stream", {8'h0, rx[23:0]},
            {8'h0, pat(base), pat(base + 1), pat(base + 2)});
    end
    $display("test reads done");
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 256; i++) begin
      @(posedge ref_clk);
      mem_we <= 1'b1;
      mem_addr <= 8'(i);
      mem_wdata <= pat(i);
    end
    @(posedge ref_clk);
    mem_we <= 1'b0;
    t_latch;
    t_nv;
    t_short;
    t_vol;
    t_reads;
    results;
  end

  // the run needs under 20k cycles; the limit stays below 100k
  initial begin
    #900000;
    failures++;
    $display("watchdog expired");
    results;
  end
endmodule
